/* File: rtl/scl_pkg.sv */
// scl_pkg: constants, carriers and states of the serial configuration loader
// assumes a 20 MHz system clock; all timing counts derive from its period
package scl_pkg;

   // system clock period
   localparam int MCLK_PERIOD_NS = 50;

   // request low to status/done low, longest time
   localparam int T_REQ_REACT_MAX_NS = 600;
   localparam int REQ_REACT_CYC = T_REQ_REACT_MAX_NS / MCLK_PERIOD_NS;

   // status low pulse, least time
   localparam int T_STATUS_MIN_US = 268;
   localparam int STATUS_MIN_CYC  =
      (T_STATUS_MIN_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   // power-on-reset delay, plain default value
   localparam int T_POR_US = 100;
   localparam int POR_CYC  = (T_POR_US * 1000) / MCLK_PERIOD_NS;

   // done high to user mode on the internal oscillator, least time
   localparam int T_INIT_MIN_US = 175;
   localparam int INIT_MIN_CYC  =
      (T_INIT_MIN_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   // user start-up clock cycles needed for initialization
   localparam int USR_INIT_CYCLES = 8576;

   // done high to user clock enabled: four periods of the fastest host clock
   localparam int HOST_CLK_MAX_MHZ = 125;
   localparam int T_CD2CU_NS       = 4 * 1000 / HOST_CLK_MAX_MHZ;
   localparam int CD2CU_RAW        =
      (T_CD2CU_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int CD2CU_CYC        = (CD2CU_RAW < 1) ? 1 : CD2CU_RAW;

   // flash clock rate maxima in tenths of MHz: 12.5, 25.0, 50.0, 100.0
   localparam int RATE_TENTH_MHZ [4] = '{125, 250, 500, 1000};
   localparam logic [1:0] RATE_FASTEST = 2'h3;
   localparam logic [1:0] RATE_CHAIN_CAP = 2'h2;

   // half period of the flash clock in system cycles, never below one
   function automatic logic [7:0] half_cyc(input logic [1:0] rate);
      int t;
      t = RATE_TENTH_MHZ[rate] * MCLK_PERIOD_NS;
      t = (5000 * 10 + t - 1) / t;
      if (t < 1) begin
         t = 1;
      end
      return t[7:0];
   endfunction

   // stream framing
   localparam logic [7:0]  PREAMBLE_BYTE   = 8'hA5;
   localparam logic [7:0]  CMD_READ_SINGLE = 8'h03;
   localparam logic [7:0]  CMD_READ_QUAD   = 8'h6B;
   localparam logic [23:0] FLASH_START     = 24'h000000;
   localparam logic [5:0]  CMD_BITS        = 6'h20;

   // strap pins sampled from the board
   typedef struct packed {
      logic       flash_master_mode; // device clocks a flash
      logic       quad;              // four data lines per clock
      logic       chain;             // several devices share the flash
      logic [1:0] rate;              // flash clock rate select
   } scl_mode_t;

   // option byte carried in the stream after the preamble
   typedef struct packed {
      logic [4:0] rsvd;         // unused
      logic       user_pin_out; // serial pin drives in user mode
      logic       usr_clk_sel;  // initialize on the user start-up clock
      logic       init_done_en; // start-up-complete pin enabled
   } scl_opt_t;

   // loader states, one-hot
   typedef enum logic [7:0] {
      ST_POR   = 8'h01,
      ST_CLEAR = 8'h02,
      ST_WAITS = 8'h04,
      ST_LOAD  = 8'h08,
      ST_DONEW = 8'h10,
      ST_INIT  = 8'h20,
      ST_USER  = 8'h40,
      ST_ERR   = 8'h80
   } scl_state_t;

endpackage

/* File: rtl/scl_link_rx.sv */
// scl_link_rx: host-clocked receiver of the serial bit stream
// assumes clr_i and done_i are flip-flop outputs of the system domain
`timescale 1ns/1ps
module scl_link_rx (
   input  wire logic       cfg_bit_clock_i, // host-driven link clock
   input  wire logic       clr_i,           // holds the receiver cleared
   input  wire logic       done_i,          // done line level
   input  wire logic       host_serial_bit_i, // serial data from host
   output logic [7:0]      byte_o,          // last complete byte
   output logic            byte_tog_o,      // toggles per byte
   output logic            fell2_o          // two falls seen after done
);
   logic [2:0] bit_cnt_q;  // bits of the current byte
   logic [6:0] shift_q;    // partial byte, msb first
   logic [1:0] fall_cnt_q; // falling edges after done

   // one bit per rising edge; async clear is released by the protocol
   // well before the first edge, so no edge lands near the release
   always_ff @(posedge cfg_bit_clock_i or posedge clr_i) begin
      if (clr_i) begin
         bit_cnt_q  <= 3'h0;
         shift_q    <= 7'h00;
         byte_o     <= 8'h00;
         byte_tog_o <= 1'b0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q   <= {shift_q[5:0], host_serial_bit_i};
         if (bit_cnt_q == 3'h7) begin
            // a full byte: publish it and flip the event toggle
            byte_o     <= {shift_q, host_serial_bit_i};
            byte_tog_o <= ~byte_tog_o;
         end
      end
   end

   // count falling edges while done is high, saturating at two
   always_ff @(negedge cfg_bit_clock_i or negedge done_i) begin
      if (!done_i) begin
         fall_cnt_q <= 2'h0;
      end else if (fall_cnt_q != 2'h2) begin
         fall_cnt_q <= fall_cnt_q + 2'h1;
      end
   end

   assign fell2_o = fall_cnt_q[1];
endmodule

/* File: rtl/scl_loader.sv */
// scl_loader: serial configuration loader, flash-master and host-driven
// assumes pins are asynchronous to MCLK_I; CFG_CLK_I comes from the host
`timescale 1ns/1ps
module scl_loader
   import scl_pkg::*;
#(
   parameter int CFG_BYTES      = 16,             // payload bytes
   parameter int STATUS_MIN     = STATUS_MIN_CYC, // status low cycles
   parameter int USR_INIT_COUNT = USR_INIT_CYCLES // user clock cycles
) (
   input  wire logic       MCLK_I,             // system clock
   input  wire logic       RSTN_I,             // sync reset, low
   input  wire logic       CFG_CLK_I,          // host link clock
   input  wire logic       RECONFIG_REQUEST_N_I, // restart request
   input  wire logic       LOADER_STATUS_N_I,  // status pin level
   output logic            LOADER_STATUS_N_O,  // status drive value
   output logic            LOADER_STATUS_N_OE_N_O, // status enable
   output logic            LOAD_COMPLETE_O,    // done line
   output logic            INIT_DONE_O,        // start-up complete
   output logic            USER_MODE_O,        // user mode reached
   input  wire scl_mode_t  MODE_I,             // strap pins
   output logic            CFG_BIT_CLOCK_O,    // flash clock out
   output logic            CFG_BIT_CLOCK_OE_N_O, // flash clock enable
   output logic            FLASH_SEL_N_O,      // flash select
   output logic            FLASH_COMMAND_OUT_O, // command/address bit
   output logic            FLASH_COMMAND_OUT_OE_N_O, // command enable
   input  wire logic [3:0] FLASH_QUAD_LINES_I, // flash data lines
   input  wire logic       HOST_SERIAL_BIT_I,  // serial pin level
   output logic            HOST_SERIAL_BIT_O,  // serial pin drive
   output logic            HOST_SERIAL_BIT_OE_N_O, // serial enable
   input  wire logic       USER_PIN_DATA_I,    // user value for pin
   output logic            USER_PIN_O,         // pin read back
   input  wire logic       USR_CLK_I           // user start-up clock
);
   localparam int REACT_MAX = REQ_REACT_CYC; // assertion bound
   localparam int SYNC_W = 15;               // synchronised inputs

   scl_state_t  state_q, state_d; // loader state
   logic [15:0] tmr_q;            // cycles in current state
   logic [15:0] usr_cnt_q;        // user clock rising edges
   logic [SYNC_W-1:0] meta_q;     // first synchroniser stage
   logic [SYNC_W-1:0] sync_q;     // second synchroniser stage
   logic        req_n_s, stat_n_s, fell2_s, tog_s, host_bit_s, uclk_s;
   logic [3:0]  quad_s;           // synced flash lines
   scl_mode_t   mode_s;           // synced straps
   logic        uclk_prev_q;      // edge detect of user clock
   logic        tog_prev_q;       // last seen byte toggle
   logic [7:0]  link_byte;        // byte from the link receiver
   logic        link_tog, link_fell2;
   logic        clr_q;            // link receiver clear
   logic        done_q;           // done line register
   logic        stat_drv_q;       // status pulled low
   logic        init_n_q;         // start-up-complete pin
   logic        user_q;           // user mode flag
   scl_opt_t    opt_q;            // option byte
   logic        opt_ok_q;         // option byte loaded
   logic [15:0] byte_cnt_q;       // bytes accepted
   logic        byte_vld;         // one byte arrived this cycle
   logic [7:0]  byte_val;         // that byte
   logic        load_ok;          // all bytes received
   logic        bad_pre;          // preamble mismatch
   logic [1:0]  rate_q;           // effective flash rate
   logic [7:0]  div_q;            // flash clock divider
   logic        fclk_q;           // flash clock level
   logic        fall_evt;         // flash clock falls this cycle
   logic [1:0]  fall_dly_q;       // fall aligned with synced data
   logic [5:0]  cmd_cnt_q;        // command bits still to send
   logic [31:0] cmd_sh_q;         // command and address shifter
   logic [7:0]  a_sh_q;           // flash byte being assembled
   logic [2:0]  a_cnt_q;          // flash bits in that byte
   logic        a_vld_q;          // flash byte complete
   logic        master, in_load;

   // two-flop synchronisers for every pin-level input
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         meta_q <= 15'h7FFF;
         sync_q <= 15'h7FFF;
      end else begin
         meta_q <= {RECONFIG_REQUEST_N_I, LOADER_STATUS_N_I, link_fell2,
                    link_tog, HOST_SERIAL_BIT_I, USR_CLK_I,
                    FLASH_QUAD_LINES_I, MODE_I};
         sync_q <= meta_q;
      end
   end
   assign {req_n_s, stat_n_s, fell2_s, tog_s, host_bit_s, uclk_s,
           quad_s, mode_s} = sync_q;

   assign master  = mode_s.flash_master_mode;
   assign in_load = (state_q == ST_LOAD);

   // link receiver on the host clock
   scl_link_rx u_link (
      .cfg_bit_clock_i   (CFG_CLK_I),
      .clr_i             (clr_q),
      .done_i            (done_q),
      .host_serial_bit_i (HOST_SERIAL_BIT_I),
      .byte_o            (link_byte),
      .byte_tog_o        (link_tog),
      .fell2_o           (link_fell2)
   );

   // effective rate: the fastest setting is withheld for chains
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         rate_q <= 2'h0;
      end else if (mode_s.chain && mode_s.rate == RATE_FASTEST) begin
         rate_q <= RATE_CHAIN_CAP;
      end else begin
         rate_q <= mode_s.rate;
      end
   end

   // flash clock divider, runs only while loading in master mode
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I || !(in_load && master)) begin
         div_q  <= 8'h00;
         fclk_q <= 1'b0;
      end else if (div_q + 8'h01 >= half_cyc(rate_q)) begin
         div_q  <= 8'h00;
         fclk_q <= ~fclk_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   assign fall_evt = fclk_q && (div_q + 8'h01 >= half_cyc(rate_q))
                     && in_load && master;

   // fall event delayed to line up with the synchronised data lines
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         fall_dly_q <= 2'h0;
      end else begin
         fall_dly_q <= {fall_dly_q[0], fall_evt};
      end
   end

   // command and address shift out, changing just after each fall
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I || !in_load) begin
         cmd_cnt_q <= CMD_BITS;
         cmd_sh_q  <= {(mode_s.quad ? CMD_READ_QUAD : CMD_READ_SINGLE),
                       FLASH_START};
      end else if (fall_evt && cmd_cnt_q != 6'h00) begin
         cmd_cnt_q <= cmd_cnt_q - 6'h01;
         cmd_sh_q  <= {cmd_sh_q[30:0], 1'b0};
      end
   end

   // flash data assembly, sampled at the falling edge
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I || !in_load) begin
         a_sh_q  <= 8'h00;
         a_cnt_q <= 3'h0;
         a_vld_q <= 1'b0;
      end else if (fall_dly_q[1] && cmd_cnt_q == 6'h00) begin
         if (mode_s.quad) begin
            a_sh_q  <= {a_sh_q[3:0], quad_s};
            a_cnt_q <= a_cnt_q + 3'h4;
            a_vld_q <= (a_cnt_q == 3'h4);
         end else begin
            a_sh_q  <= {a_sh_q[6:0], quad_s[1]};
            a_cnt_q <= a_cnt_q + 3'h1;
            a_vld_q <= (a_cnt_q == 3'h7);
         end
      end else begin
         a_vld_q <= 1'b0;
      end
   end

   // byte source: flash in master mode, else the host link
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I || clr_q) begin
         tog_prev_q <= 1'b0;
      end else begin
         tog_prev_q <= tog_s;
      end
   end
   assign byte_vld = in_load && (master ? a_vld_q
                                        : (tog_s != tog_prev_q));
   assign byte_val = master ? a_sh_q : link_byte;
   assign bad_pre  = byte_vld && byte_cnt_q == 16'h0000
                     && byte_val != PREAMBLE_BYTE;
   assign load_ok  = byte_cnt_q == 16'(CFG_BYTES + 2);

   // byte counting and option capture
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I || state_q == ST_CLEAR) begin
         byte_cnt_q <= 16'h0000;
         opt_q      <= '0;
         opt_ok_q   <= 1'b0;
      end else if (byte_vld && !load_ok) begin
         byte_cnt_q <= byte_cnt_q + 16'h0001;
         if (byte_cnt_q == 16'h0001) begin
            opt_q    <= scl_opt_t'(byte_val);
            opt_ok_q <= 1'b1;
         end
      end
   end

   // user start-up clock edge counter, enabled after the hold-off
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         uclk_prev_q <= 1'b0;
         usr_cnt_q   <= 16'h0000;
      end else begin
         uclk_prev_q <= uclk_s;
         if (state_q != ST_INIT || tmr_q < 16'(CD2CU_CYC)) begin
            usr_cnt_q <= 16'h0000;
         end else if (uclk_s && !uclk_prev_q) begin
            usr_cnt_q <= usr_cnt_q + 16'h0001;
         end
      end
   end

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_POR: begin
            if (tmr_q >= 16'(POR_CYC)) begin
               state_d = ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            if (tmr_q >= 16'(STATUS_MIN) && req_n_s) begin
               state_d = ST_WAITS;
            end
         end
         ST_WAITS: begin
            if (stat_n_s) begin
               state_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (bad_pre) begin
               state_d = ST_ERR;
            end else if (load_ok) begin
               state_d = ST_DONEW;
            end
         end
         ST_DONEW: begin
            if (master || fell2_s) begin
               state_d = ST_INIT;
            end
         end
         ST_INIT: begin
            if (opt_q.usr_clk_sel
                  ? usr_cnt_q > 16'(USR_INIT_COUNT)
                  : tmr_q >= 16'(INIT_MIN_CYC)) begin
               state_d = ST_USER;
            end
         end
         ST_USER: begin
            state_d = ST_USER;
         end
         ST_ERR: begin
            state_d = ST_ERR;
         end
         default: begin
            state_d = ST_POR;
         end
      endcase
      if (state_q != ST_POR && !req_n_s) begin
         state_d = ST_CLEAR;
      end
   end

   // state register and its timer
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         state_q <= ST_POR;
         tmr_q   <= 16'h0000;
      end else begin
         state_q <= state_d;
         if (state_d != state_q) begin
            tmr_q <= 16'h0000;
         end else if (tmr_q != 16'hFFFF) begin
            tmr_q <= tmr_q + 16'h0001;
         end
      end
   end

   // line registers, all taken from the next state
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         stat_drv_q <= 1'b1;
         done_q     <= 1'b0;
         clr_q      <= 1'b1;
         user_q     <= 1'b0;
         init_n_q   <= 1'b1;
      end else begin
         stat_drv_q <= state_d inside {ST_POR, ST_CLEAR, ST_ERR};
         done_q     <= state_d inside {ST_DONEW, ST_INIT, ST_USER};
         clr_q      <= !(state_d inside {ST_WAITS, ST_LOAD});
         user_q     <= (state_d == ST_USER);
         init_n_q   <= !(opt_ok_q && opt_q.init_done_en)
                       || state_d == ST_USER;
      end
   end

   assign LOADER_STATUS_N_O      = 1'b0;
   assign LOADER_STATUS_N_OE_N_O = !stat_drv_q;
   assign LOAD_COMPLETE_O        = done_q;
   assign INIT_DONE_O            = init_n_q;
   assign USER_MODE_O            = user_q;

   // flash pins: clock and command driven only while loading as master
   assign CFG_BIT_CLOCK_O          = fclk_q;
   assign CFG_BIT_CLOCK_OE_N_O     = !(in_load && master);
   assign FLASH_SEL_N_O            = !(in_load && master);
   assign FLASH_COMMAND_OUT_O      = cmd_sh_q[31];
   assign FLASH_COMMAND_OUT_OE_N_O = !(in_load && master
                                     && cmd_cnt_q != 6'h00);

   // serial pin turns into a user pin after configuration
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         HOST_SERIAL_BIT_O      <= 1'b0;
         HOST_SERIAL_BIT_OE_N_O <= 1'b1;
         USER_PIN_O             <= 1'b0;
      end else begin
         HOST_SERIAL_BIT_O      <= USER_PIN_DATA_I;
         HOST_SERIAL_BIT_OE_N_O <= !(user_q && opt_q.user_pin_out);
         USER_PIN_O             <= user_q ? host_bit_s : 1'b0;
      end
   end

   // ---- checks
   a_req_status_low: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $fell(req_n_s) |-> ##[1:REACT_MAX] stat_drv_q)
      else $error("status not low after request");
   a_req_done_low: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $fell(req_n_s) |-> ##[1:REACT_MAX] !done_q)
      else $error("done not low after request");
   a_por_status: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $past(state_q) == ST_POR && state_q == ST_POR |-> stat_drv_q)
      else $error("status released during power-on delay");
   a_done_cause: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $rose(done_q) |-> $past(load_ok) && opt_ok_q)
      else $error("done rose before full stream");
   a_status_width: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $fell(stat_drv_q) |-> $past(tmr_q) >= 16'(STATUS_MIN))
      else $error("status pulse too short");
   a_osc_init_len: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $rose(user_q) && !opt_q.usr_clk_sel
      |-> $past(tmr_q) >= 16'(INIT_MIN_CYC))
      else $error("oscillator initialization too short");
   a_usr_init_len: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $rose(user_q) && opt_q.usr_clk_sel
      |-> $past(usr_cnt_q) > 16'(USR_INIT_COUNT))
      else $error("user clock initialization too short");
   a_chain_rate: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $past(mode_s.chain) |-> rate_q != RATE_FASTEST)
      else $error("fastest rate used in chain");
   a_cmd_on_fall: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      in_load && $past(in_load) && $changed(cmd_cnt_q)
      |-> $past(fall_evt))
      else $error("command changed without falling edge");
   a_init_pin_low: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      state_q == ST_INIT && $past(state_q) == ST_INIT
      && opt_q.init_done_en |-> !init_n_q)
      else $error("start-up pin high during initialization");
   a_user_lines: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      state_q == ST_USER && $past(state_q) == ST_USER
      |-> done_q && !stat_drv_q && user_q)
      else $error("lines not high in user mode");
   c_user_host: cover property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $rose(user_q) && !master);
   c_user_quad: cover property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $rose(user_q) && master && mode_s.quad);
   c_bad_stream: cover property (@(posedge MCLK_I) disable iff (!RSTN_I)
      state_q == ST_ERR);
   c_restart: cover property (@(posedge MCLK_I) disable iff (!RSTN_I)
      $past(user_q) && state_q == ST_CLEAR);
endmodule

/* File: tb/scl_host.sv */
// scl_host: behavioural host of the passive serial load
// assumes the loader samples the bit on each rising link clock edge
`timescale 1ns/1ps
module scl_host (
   output logic clk_o, // link clock, still between frames
   output logic bit_o  // serial data bit
);
   // idle levels at time zero
   initial begin
      clk_o = 1'b0;
      bit_o = 1'b0;
   end
   // one byte msb first, bit set up while clock low
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         bit_o = b[i];
         #62.5 clk_o = 1'b1;
         #62.5 clk_o = 1'b0;
      end
      bit_o = ~b[0]; // released: never the stale value
   endtask
   // two falls after done, then clock held low
   task automatic two_falls();
      repeat (2) begin
         #62.5 clk_o = 1'b1;
         #62.5 clk_o = 1'b0;
      end
   endtask
endmodule

/* File: tb/scl_loader_test.sv */
// scl_loader_test: passive loads, restarts and both init clocks
// assumes status pin has a pull-up; flash lines unused here
`timescale 1ns/1ps
module scl_loader_test;
   import scl_pkg::*;
   localparam int NB = 2; // payload bytes
   logic mclk, rstn, req_n, uclk, udata, cclk, hbit, so, soe, done;
   logic idone, user, ho, hoe, upin;
   scl_mode_t mode;
   int err_count, cmp_count, n;
   logic [7:0] q[$]; // model: bytes of the current load
   wire logic stat = soe ? 1'b1 : so;  // open drain with pull-up
   wire logic sbit = hoe ? hbit : ho;  // shared serial pin
   scl_host u_scl_host (.clk_o(cclk), .bit_o(hbit));
   scl_loader #(.CFG_BYTES(NB), .STATUS_MIN(20), .USR_INIT_COUNT(8))
   u_scl_loader (.MCLK_I(mclk), .RSTN_I(rstn), .CFG_CLK_I(cclk),
      .RECONFIG_REQUEST_N_I(req_n), .LOADER_STATUS_N_I(stat),
      .LOADER_STATUS_N_O(so), .LOADER_STATUS_N_OE_N_O(soe),
      .LOAD_COMPLETE_O(done), .INIT_DONE_O(idone), .USER_MODE_O(user),
      .MODE_I(mode), .CFG_BIT_CLOCK_O(), .CFG_BIT_CLOCK_OE_N_O(),
      .FLASH_SEL_N_O(), .FLASH_COMMAND_OUT_O(),
      .FLASH_COMMAND_OUT_OE_N_O(), .FLASH_QUAD_LINES_I(4'h0),
      .HOST_SERIAL_BIT_I(sbit), .HOST_SERIAL_BIT_O(ho),
      .HOST_SERIAL_BIT_OE_N_O(hoe), .USER_PIN_DATA_I(udata),
      .USER_PIN_O(upin), .USR_CLK_I(uclk));
   always #25 mclk = ~mclk;
   always #500 uclk = ~uclk;
   // compare and count
   task automatic chk(input string s, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", s, e, g);
      end
   endtask
   // verdict and end of run
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // wait for status release, then stream preamble, option, payload
   task automatic load(input logic [7:0] pre, input logic [7:0] opt);
      q = {pre, opt};
      repeat (NB) q.push_back(8'($urandom));
      for (n = 0; n < 40000 && stat !== 1'b1; n++) @(posedge mclk);
      chk("status released", 1'b1, stat);
      #2000;
      foreach (q[i]) u_scl_host.send_byte(q[i]);
      repeat (8) @(posedge mclk);
      #1 chk("done", q[0] == PREAMBLE_BYTE, done);
   endtask
   // two falls, count cycles until user mode
   task automatic to_user();
      u_scl_host.two_falls();
      for (n = 0; n < 10000 && user !== 1'b1; n++) @(posedge mclk);
      #1 chk("user lines", 1'b1, user & done & stat & idone);
   endtask
   // restart request held 2.6 us
   task automatic reconfig();
      @(posedge mclk) #1 req_n = 1'b0;
      repeat (REQ_REACT_CYC) @(posedge mclk);
      #1 chk("req to done", 1'b0, done);
      chk("req to status", 1'b0, stat);
      repeat (40) @(posedge mclk);
      #1 req_n = 1'b1;
   endtask
   initial begin
      mclk = 1'b0;
      uclk = 1'b0;
      rstn = 1'b0;
      req_n = 1'b1;
      mode = '0;
      n = $urandom(32'h99D50041);
      udata = 1'($urandom);
      repeat (4) @(posedge mclk);
      #1 rstn = 1'b1;
      repeat (1000) @(posedge mclk);
      #1 chk("power-on status", 1'b0, stat);
      chk("power-on done", 1'b0, done);
      load(PREAMBLE_BYTE, 8'h00);
      to_user();
      chk("osc init", 1'b1, n >= INIT_MIN_CYC && n <= 8740);
      $display("test oscillator load ended");
      reconfig();
      load(PREAMBLE_BYTE, 8'h07);
      chk("start-up pin low", 1'b0, idone);
      to_user();
      chk("user clock init", 1'b1, n >= 160);
      repeat (4) @(posedge mclk);
      chk("user pin", udata, sbit);
      chk("user pin read", udata, upin);
      $display("test user clock load ended");
      reconfig();
      load(8'h5A, 8'h00);
      chk("bad stream status", 1'b0, stat);
      $display("test bad preamble ended");
      final_report();
   end
   // watchdog
   initial begin
      #3000000;
      err_count++;
      final_report();
   end
endmodule
